// [verilog/ref_sync_input_monitor.sv]
`timescale 1ns/1ps
module ref_sync_input_monitor import ref_sync_pkg::*; #(
	parameter int PER_W = 20,
	parameter int FRAME_W = 20,
	parameter int GST_W = 12,
	parameter int PFM_INTERVAL = PFM_INTERVAL_CYC,
	parameter int ACQ_CYC = LOCK_ACQ_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [NUM_REF-1:0] reference_clock_in_i,
	input wire logic [NUM_SYNC-1:0] frame_align_in_i,
	input wire logic [NUM_REF-1:0] custom_en_i,
	input wire logic [13:0] custom_mult_i,
	input wire logic [4:0] pfm_reject_shift_i,
	input wire logic [4:0] pfm_accept_shift_i,
	input wire logic [GST_W-1:0] gst_upper_i,
	input wire logic [GST_W-1:0] gst_lower_i,
	input wire logic [1:0] gst_decay_rate_i,
	input wire logic [NUM_SYNC*FRAME_W-1:0] sync_expected_i,
	input wire logic [NUM_LOOP-1:0] loop_manual_i,
	input wire logic [NUM_LOOP*3-1:0] loop_manual_sel_i,
	output logic [NUM_REF*4-1:0] ref_code_o,
	output logic [NUM_REF-1:0] scm_fail_o,
	output logic [NUM_REF-1:0] cfm_fail_o,
	output logic [NUM_REF-1:0] pfm_fail_o,
	output logic [NUM_REF-1:0] gst_fail_o,
	output logic [NUM_REF-1:0] ref_qualified_o,
	output logic [NUM_SYNC*3-1:0] sync_code_o,
	output logic [NUM_SYNC-1:0] sync_fail_o,
	output logic [NUM_LOOP*2-1:0] loop_mode_o,
	output logic [NUM_LOOP*3-1:0] loop_sel_o,
	output logic [1:0] frame_align_sel_o,
	output logic frame_align_valid_o,
	output logic frame_align_pulse_o
);

	// ---------------------------------------------------------------
	// lookup functions
	// ---------------------------------------------------------------
	function automatic logic [3:0] ref_detect(input logic [PER_W-1:0] p);
		logic [3:0] c;
		longint d;
		c = CODE_NONE;
		d = 0;
		for (int i = 0; i < NUM_CODES; i++) begin
			// period times frequency within 1/8 of the master rate, exact
			d = longint'(p) * REF_HZ[i] - CLK_HZ;
			if (d <= longint'(CLK_HZ >>> DET_TOL_SHIFT) &&
				-d <= longint'(CLK_HZ >>> DET_TOL_SHIFT)) begin
				c = 4'(i);
			end
		end
		return c;
	endfunction

	function automatic logic [2:0] sync_detect(input logic [PER_W-1:0] p);
		logic [2:0] c;
		int n;
		c = SYNC_NONE;
		n = 0;
		for (int i = 0; i < NUM_SYNC_CODES; i++) begin
			n = SYNC_PERIOD_NS[i] / CLK_NS;
			if (int'(p) >= n - (n >>> DET_TOL_SHIFT) &&
				int'(p) <= n + (n >>> DET_TOL_SHIFT)) begin
				c = 3'(i);
			end
		end
		return c;
	endfunction

	function automatic logic [PER_W-1:0] ref_period(input logic [3:0] c);
		logic [PER_W-1:0] p;
		p = '0;
		for (int i = 0; i < NUM_CODES; i++) begin
			if (c == 4'(i)) begin
				p = PER_W'(CLK_HZ / REF_HZ[i]);
			end
		end
		return p;
	endfunction

	// expected edges per interval, counted on the master clock
	function automatic logic [31:0] ref_expect(input logic [3:0] c);
		logic [31:0] e;
		e = '0;
		for (int i = 0; i < NUM_CODES; i++) begin
			if (c == 4'(i)) begin
				e = 32'(longint'(REF_HZ[i]) * PFM_INTERVAL / CLK_HZ);
			end
		end
		return e;
	endfunction

	function automatic logic [2:0] pick_lowest(input logic [NUM_REF-1:0] q);
		logic [2:0] s;
		s = '0;
		for (int i = NUM_REF - 1; i >= 0; i--) begin
			if (q[i]) begin
				s = 3'(i);
			end
		end
		return s;
	endfunction

	// ---------------------------------------------------------------
	// input synchronisers and period counters
	// ---------------------------------------------------------------
	logic [NUM_IN-1:0] rise;
	logic [NUM_REF-1:0] qual;
	logic [PER_W-1:0] cust_per;
	logic [10:0] win_q;
	logic win_end;
	logic [15:0] dec_q;
	logic decay_tick;
	logic [15:0] dec_load;

	edge_sync #(
		.W(NUM_IN)
	) u_edge (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.d_i({frame_align_in_i, reference_clock_in_i}),
		.rise_o(rise)
	);

	for (genvar i = 0; i < NUM_IN; i++) begin : g_in
		logic [PER_W-1:0] run_q;
		logic [PER_W-1:0] per_now;
		logic lost;
		assign per_now = run_q + PER_W'(1);
		assign lost = &run_q;
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				run_q <= '0;
			end else if (rise[i]) begin
				run_q <= '0;
			end else if (!lost) begin
				run_q <= per_now;
			end
		end
	end

	// custom nominal period, master clock cycles
	assign cust_per = (custom_mult_i == 14'h0000) ? '0 :
		PER_W'((CLK_HZ / BASE_FRAME_HZ) / int'(custom_mult_i));

	// ---------------------------------------------------------------
	// shared timers: coarse window and guard soak decay
	// ---------------------------------------------------------------
	assign win_end = (win_q == 11'(CFM_WINDOW_CYC - 1));
	assign decay_tick = (dec_q == 16'h0000);
	assign dec_load = 16'(GST_DECAY_BASE_CYC) << {gst_decay_rate_i, 1'b0};

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			win_q <= '0;
			dec_q <= '0;
		end else begin
			win_q <= win_end ? '0 : win_q + 11'h001;
			dec_q <= decay_tick ? dec_load : dec_q - 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// per reference monitors
	// ---------------------------------------------------------------
	for (genvar r = 0; r < NUM_REF; r++) begin : g_ref
		logic [3:0] code_q;
		logic valid;
		logic [PER_W-1:0] nom;
		logic [PER_W-1:0] tol;
		logic [PER_W-1:0] per;
		logic scm_ev;
		logic scm_q;
		logic [9:0] cnt_q;
		logic [9:0] cnt_nx;
		logic [9:0] prev_q;
		logic [9:0] cdiff;
		logic cfm_ev;
		logic cfm_q;
		logic [31:0] pt_q;
		logic [31:0] pe_q;
		logic [31:0] pe_nx;
		logic [31:0] pexp;
		logic [31:0] perr;
		logic pfm_end;
		logic pfm_q;
		logic [GST_W-1:0] acc_q;
		logic gst_q;
		logic qual_q;

		assign per = g_in[r].per_now;
		assign valid = (code_q != CODE_NONE);
		assign nom = custom_en_i[r] ? cust_per : ref_period(code_q);
		assign tol = PER_W'(int'(nom) * SCM_TOL_PCT / 100);
		// bad period at an edge, or no edge by nominal plus tolerance
		assign scm_ev = valid & ((rise[r] & (per > nom + tol ||
			per + tol < nom)) | (~rise[r] &
			g_in[r].run_q == nom + tol));

		assign cnt_nx = cnt_q + 10'(rise[r]);
		assign cdiff = (cnt_nx > prev_q) ? cnt_nx - prev_q : prev_q - cnt_nx;
		assign cfm_ev = win_end & (prev_q >= 10'(CFM_MIN_EDGES)) &
			(int'(cdiff) * 100 > int'(prev_q) * CFM_TOL_PCT);

		assign pe_nx = pe_q + 32'(rise[r]);
		assign pfm_end = (pt_q == 32'(PFM_INTERVAL - 1));
		// one product before the division keeps the fraction of a frame
		assign pexp = custom_en_i[r] ?
			32'(longint'(custom_mult_i) * BASE_FRAME_HZ * PFM_INTERVAL /
			CLK_HZ) : ref_expect(code_q);
		assign perr = (pe_nx > pexp) ? pe_nx - pexp : pexp - pe_nx;

		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				code_q <= CODE_NONE;
				scm_q <= 1'b0;
			end else begin
				if (rise[r]) begin
					code_q <= custom_en_i[r] ? CODE_CUSTOM : ref_detect(per);
				end else if (g_in[r].lost) begin
					code_q <= CODE_NONE;
				end
				if (scm_ev) begin
					scm_q <= 1'b1;
				end else if (rise[r]) begin
					scm_q <= 1'b0;
				end
			end
		end

		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				cnt_q <= '0;
				prev_q <= '0;
				cfm_q <= 1'b0;
			end else if (win_end) begin
				cnt_q <= '0;
				prev_q <= cnt_nx;
				cfm_q <= cfm_ev;
			end else begin
				cnt_q <= cnt_nx;
			end
		end

		// references start failed from reset until a full interval passes
		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				pt_q <= '0;
				pe_q <= '0;
				pfm_q <= 1'b1;
			end else if (scm_ev | cfm_ev | ~valid) begin
				pt_q <= '0;
				pe_q <= '0;
			end else if (pfm_end) begin
				pt_q <= '0;
				pe_q <= '0;
				if (perr > (pexp >> pfm_reject_shift_i)) begin
					pfm_q <= 1'b1;
				end else if (perr <= (pexp >> pfm_accept_shift_i)) begin
					pfm_q <= 1'b0;
				end
			end else begin
				pt_q <= pt_q + 32'h0000_0001;
				pe_q <= pe_nx;
			end
		end

		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				acc_q <= '0;
				gst_q <= 1'b0;
			end else begin
				if ((scm_ev | cfm_ev) & ~&acc_q) begin
					acc_q <= acc_q + GST_W'(1);
				end else if (~(scm_ev | cfm_ev) & decay_tick &
					acc_q != '0) begin
					acc_q <= acc_q - GST_W'(1);
				end
				if (acc_q >= gst_upper_i) begin
					gst_q <= 1'b1;
				end else if (acc_q <= gst_lower_i) begin
					gst_q <= 1'b0;
				end
			end
		end

		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				qual_q <= 1'b0;
			end else begin
				qual_q <= valid & ~(scm_q | cfm_q | pfm_q | gst_q);
			end
		end

		assign qual[r] = qual_q;
		assign ref_code_o[4*r+:4] = code_q;
		assign scm_fail_o[r] = scm_q;
		assign cfm_fail_o[r] = cfm_q;
		assign pfm_fail_o[r] = pfm_q;
		assign gst_fail_o[r] = gst_q;
		assign ref_qualified_o[r] = qual_q;
	end

	// ---------------------------------------------------------------
	// frame input monitors
	// ---------------------------------------------------------------
	for (genvar s = 0; s < NUM_SYNC; s++) begin : g_sync
		logic [2:0] scode_q;
		logic [FRAME_W-1:0] fc_q;
		logic [FRAME_W-1:0] fc_nx;
		logic seen_q;
		logic sfail_q;
		logic sr;

		assign sr = rise[NUM_REF+s];
		// reference n is the counting clock of frame input n
		assign fc_nx = fc_q + FRAME_W'(rise[s]);

		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				scode_q <= SYNC_NONE;
				fc_q <= '0;
				seen_q <= 1'b0;
				sfail_q <= 1'b0;
			end else begin
				if (sr) begin
					scode_q <= sync_detect(g_in[NUM_REF+s].per_now);
					fc_q <= '0;
					seen_q <= 1'b1;
					if (seen_q) begin
						sfail_q <= (fc_nx != sync_expected_i[FRAME_W*s+:FRAME_W]);
					end
				end else begin
					if (~&fc_q) begin
						fc_q <= fc_nx;
					end
					if (g_in[NUM_REF+s].lost) begin
						scode_q <= SYNC_NONE;
					end
				end
			end
		end

		assign sync_code_o[3*s+:3] = scode_q;
		assign sync_fail_o[s] = sfail_q;
	end

	// ---------------------------------------------------------------
	// reference selectors, index 0 is the primary_loop
	// ---------------------------------------------------------------
	for (genvar l = 0; l < NUM_LOOP; l++) begin : g_loop
		loop_mode_type st_q;
		logic [2:0] sel_q;
		logic [15:0] acq_q;
		logic hist_q;
		logic manual;
		logic [2:0] msel;
		logic [2:0] tgt;
		logic avail;
		logic cur_ok;
		logic acq_done;

		assign manual = loop_manual_i[l];
		assign msel = loop_manual_sel_i[3*l+:3];
		// only qualified references are candidates
		assign tgt = manual ? msel : pick_lowest(qual);
		assign avail = manual ? qual[msel] : |qual;
		assign cur_ok = qual[sel_q] & (~manual | sel_q == msel);
		assign acq_done = (acq_q == 16'(ACQ_CYC - 1));

		always_ff @(posedge clk_i or negedge rst_b_i) begin
			if (!rst_b_i) begin
				st_q <= FREE_RUN;
				sel_q <= '0;
				acq_q <= '0;
				hist_q <= 1'b0;
			end else begin
				case (st_q)
				FREE_RUN, HOLDOVER: begin
					if (avail) begin
						sel_q <= tgt;
						acq_q <= '0;
						st_q <= ACQUIRE;
					end
				end
				ACQUIRE: begin
					if (!cur_ok) begin
						if (avail) begin
							sel_q <= tgt;
							acq_q <= '0;
						end else begin
							st_q <= hist_q ? HOLDOVER : FREE_RUN;
						end
					end else if (acq_done) begin
						st_q <= LOCKED;
						hist_q <= 1'b1;
					end else begin
						acq_q <= acq_q + 16'h0001;
					end
				end
				LOCKED: begin
					if (!cur_ok) begin
						if (avail) begin
							sel_q <= tgt;
							acq_q <= '0;
							st_q <= ACQUIRE;
						end else begin
							st_q <= HOLDOVER;
						end
					end
				end
				default: begin
					st_q <= FREE_RUN;
				end
				endcase
			end
		end

		assign loop_mode_o[2*l+:2] = st_q;
		assign loop_sel_o[3*l+:3] = sel_q;
	end

	// ---------------------------------------------------------------
	// frame alignment follows the primary_loop selection only
	// ---------------------------------------------------------------
	logic fa_valid;
	logic fa_rise;
	logic fa_pulse_q;

	assign fa_valid = (g_loop[0].sel_q < 3'(NUM_SYNC)) &
		(g_loop[0].st_q != FREE_RUN);
	assign fa_rise = rise[NUM_REF + int'(g_loop[0].sel_q[1:0])];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fa_pulse_q <= 1'b0;
		end else begin
			fa_pulse_q <= fa_valid & fa_rise;
		end
	end

	assign frame_align_sel_o = g_loop[0].sel_q[1:0];
	assign frame_align_valid_o = fa_valid;
	assign frame_align_pulse_o = fa_pulse_q;

endmodule // ref_sync_input_monitor

// [common/ref_sync_pkg.sv]
package ref_sync_pkg;

	// ---------------------------------------------------------------
	// clock, sizes
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
	localparam int NUM_REF = 8;
	localparam int NUM_SYNC = 3;
	localparam int NUM_IN = NUM_REF + NUM_SYNC;
	localparam int NUM_LOOP = 2;

	// ---------------------------------------------------------------
	// auto-detect sets
	// ---------------------------------------------------------------
	localparam int NUM_CODES = 11;
	localparam int REF_HZ [NUM_CODES] = '{2000, 8000, 64000, 1544000,
		2048000, 6480000, 8192000, 16384000, 19440000, 38880000,
		77760000};
	localparam int REF_MIN_HZ = 2000;
	localparam int REF_MAX_HZ = 77760000;
	localparam int BASE_FRAME_HZ = 8000;
	localparam int NUM_SYNC_CODES = 6;
	// 48 base frames, 400 Hz, 1 kHz, 2 kHz, 8 kHz, 64 kHz
	localparam int SYNC_PERIOD_NS [NUM_SYNC_CODES] = '{6000000,
		2500000, 1000000, 500000, 125000, 15625};
	localparam int DET_TOL_SHIFT = 3;
	localparam logic [3:0] CODE_NONE = 4'hF;
	localparam logic [3:0] CODE_CUSTOM = 4'hE;
	localparam logic [2:0] SYNC_NONE = 3'h7;

	// ---------------------------------------------------------------
	// monitor timing
	// ---------------------------------------------------------------
	localparam int SCM_TOL_PCT = 50;
	localparam int CFM_WINDOW_NS = 30000;
	localparam int CFM_WINDOW_CYC = CFM_WINDOW_NS / CLK_NS;
	localparam int CFM_TOL_PCT = 3;
	localparam int CFM_MIN_EDGES = 100 / CFM_TOL_PCT + 1;
	localparam int PFM_INTERVAL_S = 10;
	localparam int PFM_INTERVAL_CYC = PFM_INTERVAL_S * CLK_HZ;
	localparam int GST_DECAY_BASE_CYC = 256;
	localparam int LOCK_ACQ_CYC = 1024;

	typedef enum logic [1:0] {
		FREE_RUN,
		ACQUIRE,
		LOCKED,
		HOLDOVER
	} loop_mode_type;

endpackage

// [verilog/edge_sync.sv]
`timescale 1ns/1ps
module edge_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] rise_o
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign rise_o = s2_q & ~s3_q;

endmodule // edge_sync

// [bench/ref_source.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// reference and frame pulse sources
// ---------------------------------------------------------------
module ref_source #(
	parameter int HALF_NS = 80,
	parameter int FRAME_CYC = 781
) (
	input wire logic [7:0] en_i,
	input wire logic frame_en_i,
	output logic [7:0] ref_o,
	output logic [2:0] frame_o
);
	logic base = 1'b0;
	int cnt = 0;
	// odd start offset keeps reference edges off the master clock edges
	initial begin
		#3;
		forever begin
			#HALF_NS base = ~base;
		end
	end
	always @(posedge base) begin
		cnt <= (cnt + 1) % FRAME_CYC;
	end
	// a disabled reference stands still low
	assign ref_o = en_i & {8{base}};
	// frame high for two reference periods, far above the minimum width
	assign frame_o = {2'b00, frame_en_i && en_i[0] && cnt < 2};
endmodule // ref_source

// [bench/ref_sync_input_monitor_properties.sv]
`timescale 1ns/1ps
module ref_sync_input_monitor_properties import ref_sync_pkg::*; #(
	parameter int ACQ_CYC = LOCK_ACQ_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [NUM_LOOP-1:0] loop_manual_i,
	input wire logic [NUM_LOOP*3-1:0] loop_manual_sel_i,
	input wire logic [NUM_REF-1:0] scm_fail_o,
	input wire logic [NUM_REF-1:0] cfm_fail_o,
	input wire logic [NUM_REF-1:0] pfm_fail_o,
	input wire logic [NUM_REF-1:0] gst_fail_o,
	input wire logic [NUM_REF-1:0] ref_qualified_o,
	input wire logic [NUM_LOOP*2-1:0] loop_mode_o,
	input wire logic [NUM_LOOP*3-1:0] loop_sel_o,
	input wire logic [1:0] frame_align_sel_o,
	input wire logic frame_align_valid_o,
	input wire logic frame_align_pulse_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	wire logic [NUM_REF-1:0] any_fail;
	wire logic [1:0] m0;
	wire logic [1:0] m1;
	logic [15:0] acq_q;
	logic [15:0] acq_d;
	assign any_fail = scm_fail_o | cfm_fail_o | pfm_fail_o | gst_fail_o;
	assign m0 = loop_mode_o[1:0];
	assign m1 = loop_mode_o[3:2];
	// cycles spent acquiring on the primary loop
	assign acq_d = (m0 == ACQUIRE) ? acq_q + 16'h0001 : 16'h0000;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			acq_q <= 16'h0000;
		else
			acq_q <= acq_d;
	end
	property p_qual;
		ref_qualified_o == ~$past(any_fail);
	endproperty
	a_qual: assert property (p_qual)
		else $error("qualified does not follow monitor fails");
	property p_acq;
		(m0 == FREE_RUN || m0 == HOLDOVER) ##1 (m0 == ACQUIRE)
			|-> $past(|ref_qualified_o);
	endproperty
	a_acq: assert property (p_acq)
		else $error("acquire entered without a qualified reference");
	property p_hold;
		(m0 == LOCKED) && !loop_manual_i[0] ##1 (m0 == HOLDOVER)
			|-> $past(ref_qualified_o) == '0;
	endproperty
	a_hold: assert property (p_hold)
		else $error("holdover while another reference was qualified");
	property p_lock;
		$rose(m0 == LOCKED) |-> acq_q >= ACQ_CYC - 1;
	endproperty
	a_lock: assert property (p_lock)
		else $error("locked before acquisition time");
	property p_free;
		(m1 == FREE_RUN) |=> (m1 == FREE_RUN || m1 == ACQUIRE);
	endproperty
	a_free: assert property (p_free)
		else $error("free-run left other than to acquire");
	property p_valid;
		frame_align_valid_o == (loop_sel_o[2:0] < 3'h3 && m0 != FREE_RUN);
	endproperty
	a_valid: assert property (p_valid)
		else $error("frame align valid wrong");
	property p_fsel;
		$stable(loop_sel_o[1:0]) |-> frame_align_sel_o == loop_sel_o[1:0];
	endproperty
	a_fsel: assert property (p_fsel)
		else $error("frame input does not follow primary selection");
	property p_pulse;
		frame_align_pulse_o |=> !frame_align_pulse_o;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("frame align pulse longer than one cycle");
	property p_manual;
		loop_manual_i[1] [*4] ##0 (m1 == LOCKED)
			|-> loop_sel_o[5:3] == loop_manual_sel_i[5:3];
	endproperty
	a_manual: assert property (p_manual)
		else $error("manual loop locked on another reference");
endmodule // ref_sync_input_monitor_properties

bind ref_sync_input_monitor ref_sync_input_monitor_properties #(
	.ACQ_CYC(ACQ_CYC)
) u_props (
	.clk_i,
	.rst_b_i,
	.loop_manual_i,
	.loop_manual_sel_i,
	.scm_fail_o,
	.cfm_fail_o,
	.pfm_fail_o,
	.gst_fail_o,
	.ref_qualified_o,
	.loop_mode_o,
	.loop_sel_o,
	.frame_align_sel_o,
	.frame_align_valid_o,
	.frame_align_pulse_o
);

// [bench/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, got); \
	n_errors++; end end
`define WAITC(nm, c, lim) begin k = 0; n_checks++; \
	while ((c) !== 1'b1 && k < (lim)) begin @(negedge clk_i); k++; end \
	if ((c) !== 1'b1) begin $display("[ERR] %s expected 1 seen 0", nm); \
	n_errors++; report_and_stop(); end end
module testbench;
	import ref_sync_pkg::*;
	localparam int PFM_IV = 4000;
	localparam int ACQ = 8;
	logic clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] en, custom_en, ref_w, scm, cfm, precise_freq_monitor, gst, qual;
	logic frame_en, fvalid, fpulse;
	logic [2:0] frame_w, sync_fail;
	logic [13:0] custom_mult;
	logic [4:0] rej, acc;
	logic [11:0] gup, glo;
	logic [1:0] decay, man, fsel;
	logic [59:0] sync_exp;
	logic [5:0] man_sel, sel;
	logic [31:0] ref_code;
	logic [8:0] sync_code;
	logic [3:0] mode;
	logic [7:0] lfsr = 8'h37;
	int n_errors = 0;
	int n_checks = 0;
	int k, i, pick, npulse;
	always #10 clk_i = ~clk_i;
	ref_source u_src (.en_i(en), .frame_en_i(frame_en), .ref_o(ref_w),
		.frame_o(frame_w));
	ref_sync_input_monitor #(.PFM_INTERVAL(PFM_IV), .ACQ_CYC(ACQ)) uut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .reference_clock_in_i(ref_w),
		.frame_align_in_i(frame_w), .custom_en_i(custom_en),
		.custom_mult_i(custom_mult), .pfm_reject_shift_i(rej),
		.pfm_accept_shift_i(acc), .gst_upper_i(gup), .gst_lower_i(glo),
		.gst_decay_rate_i(decay), .sync_expected_i(sync_exp),
		.loop_manual_i(man), .loop_manual_sel_i(man_sel),
		.ref_code_o(ref_code), .scm_fail_o(scm), .cfm_fail_o(cfm),
		.pfm_fail_o(precise_freq_monitor), .gst_fail_o(gst), .ref_qualified_o(qual),
		.sync_code_o(sync_code), .sync_fail_o(sync_fail),
		.loop_mode_o(mode), .loop_sel_o(sel), .frame_align_sel_o(fsel),
		.frame_align_valid_o(fvalid), .frame_align_pulse_o(fpulse));
	// next state of the stimulus shift register
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	// period in ns to detect code, references or frame inputs
	function automatic int det(input int p, input bit s);
		int nom;
		for (int j = 0; j < (s ? NUM_SYNC_CODES : NUM_CODES); j++) begin
			nom = s ? SYNC_PERIOD_NS[j] : 1000000000 / REF_HZ[j];
			if (p >= nom - nom / 8 && p <= nom + nom / 8)
				return j;
		end
		return s ? 7 : 15;
	endfunction
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		en = 8'h00;
		frame_en = 1'b0;
		custom_en = 8'h80;
		custom_mult = 14'h030D;
		rej = 5'h03;
		acc = 5'h04;
		gup = 12'h001;
		glo = 12'h000;
		decay = 2'h0;
		sync_exp = {40'h0, 20'h0030D};
		man = 2'h2;
		lfsr = lfsr_next(lfsr);
		pick = lfsr % 6 + 1;
		man_sel = {3'(pick), 3'h0};
		repeat (10) @(negedge clk_i);
		rst_b_i = 1'b1;
		@(negedge clk_i);
		`CHK("ref_code", 32'hFFFFFFFF, ref_code)
		`CHK("sync_code", 9'h1FF, sync_code)
		`CHK("pfm_fail", 8'hFF, precise_freq_monitor)
		`CHK("mode", 4'h0, mode)
		// custom reference starts late so the lowest index qualifies first
		en = 8'h7F;
		frame_en = 1'b1;
		repeat (24) @(negedge clk_i);
		en = 8'hFF;
		repeat (976) @(negedge clk_i);
		`CHK("qual_early", 8'h00, qual)
		for (i = 0; i < 8; i++)
			`CHK("ref_code", (i == 7) ? CODE_CUSTOM : 4'(det(160, 0)), ref_code[4*i +: 4])
		`WAITC("all_qualified", &qual, 20000)
		`CHK("fails", 32'h0, {scm, cfm, precise_freq_monitor, gst})
		`WAITC("lock", mode[1:0] == LOCKED, 2000)
		`CHK("sel", {3'(pick), 3'h0}, sel)
		`CHK("frame_sel", 3'h4, {fvalid, fsel})
		`WAITC("sync_code", sync_code[2:0] != 3'h7, 20000)
		`CHK("sync_code", {6'h3F, 3'(det(124960, 1))}, sync_code)
		repeat (6300) @(negedge clk_i);
		`CHK("sync_fail", 3'h0, sync_fail)
		npulse = 0;
		repeat (2 * 6248) begin
			@(negedge clk_i);
			if (fpulse === 1'b1)
				npulse++;
		end
		`CHK("pulses", 2, npulse)
		sync_exp[19:0] = 20'h0030C;
		`WAITC("sync_fail_set", sync_fail[0], 14000)
		sync_exp[19:0] = 20'h0030D;
		`WAITC("sync_fail_clr", !sync_fail[0], 14000)
		en = 8'hFE;
		`WAITC("scm_fail", scm[0], 40)
		`WAITC("gst_fail", gst[0], 200)
		`WAITC("resel", sel[2:0] == 3'h1, 100)
		`CHK("frame_sel", 3'h5, {fvalid, fsel})
		`CHK("loop1", {2'(LOCKED), 3'(pick)}, {mode[3:2], sel[5:3]})
		en = 8'hFF;
		`WAITC("gst_clear", !gst[0], 30000)
		`CHK("requal_late", 1'b0, qual[0])
		`WAITC("requal", qual[0], 20000)
		`CHK("nonrevert", 3'h1, sel[2:0])
		en = 8'h00;
		`WAITC("holdover", mode == {2'(HOLDOVER), 2'(HOLDOVER)}, 500)
		report_and_stop();
	end
endmodule // testbench
